//--- verilog/dag_top.sv
// Contract
// - Each extended pointer holds a 23-bit word address in 64K-word pages.
// - Post-modify past a page end wraps inside the page, page bits kept.
// - A 16-bit low load writes bits 15..0 and keeps the 7 page bits.
// - A full 23-bit immediate load sets every bit of a pointer.
// - Pointer ALU arithmetic is 16 bits wide, page bits untouched.
// - The extended page pointer is 23 bits, so direct arrays need no alignment.
// - Direct instructions carry a 7-bit offset; pages span 128 words.
// - Legacy page is a 9-bit status-one field; bases keep low 7 bits zero.
// - No 23-bit base displacement; constant-base indexing reaches only 16 bits.
// - In 32-bit stack mode the system stack moves with the data stack.
// - Stack mode is taken once after reset release from a reset-vector code.
// - Data and system stack pointers share one set of 7 page bits.
`timescale 1ns/1ps
`default_nettype none
module dag_top
	import dag_pkg::*;
#(
	parameter int NUM_PTR = DAG_NUM_PTR
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Stack-mode code fetched from the reset vector
	input wire logic [DAG_VEC_W-1:0] reset_vec_code_i,
	// Pipeline command
	input wire dag_op_e op_i,
	input wire logic [DAG_SEL_W-1:0] ptr_sel_i,
	input wire logic [DAG_ADDR_W-1:0] op_data_i,
	input wire logic [DAG_OFS_W-1:0] dir_offset_i,
	// Stack command
	input wire dag_stk_op_e stk_op_i,
	input wire logic [DAG_ADDR_W-1:0] stk_data_i,
	// Pointer read port
	input wire logic [DAG_SEL_W-1:0] rd_sel_i,
	// Data memory address
	output logic [DAG_ADDR_W-1:0] addr_o,
	output logic addr_valid_o,
	// Visible state
	output logic [DAG_ADDR_W-1:0] rd_ptr_o,
	output logic [DAG_ADDR_W-1:0] extended_page_pointer_o,
	output logic [DAG_ST1_W-1:0] status_register_one_o,
	output logic stack_mode_ready_o,
	output dag_stack_mode_e stack_mode_o,
	output logic [DAG_ADDR_W-1:0] sp_addr_o,
	output logic [DAG_ADDR_W-1:0] system_stack_pointer_o
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_b;

	// Two flops so release never lands near an edge
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_b <= rst_meta;
		end
	end

	// ****************************************
	// Address helpers
	// ****************************************
	// Adds inside the current page; the carry out of bit 15 is dropped
	function automatic logic [DAG_ADDR_W-1:0] in_page_add(
		input logic [DAG_ADDR_W-1:0] base,
		input logic [DAG_LOW_W-1:0] delta
	);
		logic [DAG_LOW_W-1:0] low;
		low = base[DAG_LOW_W-1:0] + delta;
		in_page_add = {base[DAG_ADDR_W-1:DAG_LOW_W], low};
	endfunction

	// ****************************************
	// Stack mode capture
	// ****************************************
	logic mode_taken;
	dag_stack_mode_e stack_mode;
	logic next_mode_taken;
	dag_stack_mode_e next_stack_mode;

	// Code sampled once on the first edge after release, never under reset
	always_comb begin
		next_mode_taken = 1'b1;
		next_stack_mode = stack_mode;
		if (!mode_taken) begin
			if (reset_vec_code_i == DAG_VEC_FAST_RET) begin
				next_stack_mode = DAG_STK_FAST_RET;
			end else begin
				next_stack_mode = DAG_STK_ALIGNED32;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			mode_taken <= 1'b0;
			stack_mode <= DAG_STK_ALIGNED32;
		end else begin
			mode_taken <= next_mode_taken;
			stack_mode <= next_stack_mode;
		end
	end

	// ****************************************
	// Pointers, page pointer and status one
	// ****************************************
	logic [DAG_ADDR_W-1:0] ptr [NUM_PTR];
	logic [DAG_ADDR_W-1:0] next_ptr [NUM_PTR];
	logic [DAG_ADDR_W-1:0] page_ptr;
	logic [DAG_ADDR_W-1:0] next_page_ptr;
	logic [DAG_ST1_W-1:0] status_one;
	logic [DAG_ST1_W-1:0] next_status_one;
	logic [DAG_ADDR_W-1:0] sel_ptr;

	assign sel_ptr = ptr[ptr_sel_i];

	// One pointer update per command, selected by index
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
			always_comb begin
				next_ptr[gi] = ptr[gi];
				if (ptr_sel_i == DAG_SEL_W'(gi)) begin
					case (op_i)
						DAG_OP_PTR_LOAD_LOW: begin
							next_ptr[gi] = {ptr[gi][DAG_ADDR_W-1:DAG_LOW_W],
								op_data_i[DAG_LOW_W-1:0]};
						end
						DAG_OP_PTR_LOAD_FULL: begin
							next_ptr[gi] = op_data_i;
						end
						DAG_OP_PTR_ADD: begin
							next_ptr[gi] = in_page_add(ptr[gi], op_data_i[DAG_LOW_W-1:0]);
						end
						DAG_OP_IND_ACCESS: begin
							next_ptr[gi] = in_page_add(ptr[gi], op_data_i[DAG_LOW_W-1:0]);
						end
						default: begin
							next_ptr[gi] = ptr[gi];
						end
					endcase
				end
			end

			always_ff @(posedge clock_i or negedge rst_b) begin
				if (!rst_b) begin
					ptr[gi] <= DAG_ADDR_RST;
				end else begin
					ptr[gi] <= next_ptr[gi];
				end
			end
		end
	endgenerate

	// Page pointer loads; a legacy load also rebuilds the aligned base
	always_comb begin
		next_page_ptr = page_ptr;
		next_status_one = status_one;
		case (op_i)
			DAG_OP_PAGE_LOAD: begin
				next_page_ptr = op_data_i;
			end
			DAG_OP_LEGACY_LOAD: begin
				next_status_one[DAG_LEGACY_LSB +: DAG_LEGACY_W] =
					op_data_i[DAG_LEGACY_W-1:0];
				next_page_ptr = {DAG_PAGE_RST, op_data_i[DAG_LEGACY_W-1:0],
					DAG_LEGACY_ALIGN};
			end
			default: begin
				next_page_ptr = page_ptr;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			page_ptr <= DAG_ADDR_RST;
			status_one <= DAG_ST1_RST;
		end else begin
			page_ptr <= next_page_ptr;
			status_one <= next_status_one;
		end
	end

	// ****************************************
	// Address generation
	// ****************************************
	logic [DAG_ADDR_W-1:0] addr;
	logic addr_valid;
	logic [DAG_ADDR_W-1:0] rd_ptr;
	logic [DAG_ADDR_W-1:0] next_addr;
	logic next_addr_valid;
	logic [DAG_ADDR_W-1:0] dir_sum;

	// Full-width add: a direct array may straddle any boundary
	assign dir_sum = page_ptr + {{(DAG_ADDR_W-DAG_OFS_W){1'b0}}, dir_offset_i};

	// Indirect uses the pointer before its post-modify
	always_comb begin
		next_addr = addr;
		next_addr_valid = 1'b0;
		case (op_i)
			DAG_OP_IND_ACCESS: begin
				next_addr = sel_ptr;
				next_addr_valid = 1'b1;
			end
			DAG_OP_IDX_ACCESS: begin
				// Only a 16-bit base fits; it cannot leave the pointer's page
				next_addr = in_page_add(sel_ptr, op_data_i[DAG_LOW_W-1:0]);
				next_addr_valid = 1'b1;
			end
			DAG_OP_DIR_ACCESS: begin
				next_addr = dir_sum;
				next_addr_valid = 1'b1;
			end
			default: begin
				next_addr = addr;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			addr <= DAG_ADDR_RST;
			addr_valid <= 1'b0;
			rd_ptr <= DAG_ADDR_RST;
		end else begin
			addr <= next_addr;
			addr_valid <= next_addr_valid;
			rd_ptr <= ptr[rd_sel_i];
		end
	end

	// ****************************************
	// Stacks
	// ****************************************
	dag_stack u_stack (
		.clock_i(clock_i),
		.rst_b_i(rst_b),
		.stack_mode_i(stack_mode),
		.stk_op_i(stk_op_i),
		.stk_data_i(stk_data_i),
		.sp_addr_o(sp_addr_o),
		.system_stack_pointer_o(system_stack_pointer_o)
	);

	// Outputs straight from flops
	assign addr_o = addr;
	assign addr_valid_o = addr_valid;
	assign rd_ptr_o = rd_ptr;
	assign extended_page_pointer_o = page_ptr;
	assign status_register_one_o = status_one;
	assign stack_mode_ready_o = mode_taken;
	assign stack_mode_o = stack_mode;
endmodule
`default_nettype wire

//--- verilog/dag_pkg.sv
`default_nettype none
package dag_pkg;
	// ****************************************
	// Widths of the data space and its parts
	// ****************************************
	localparam int DAG_ADDR_W = 23; // Word address width
	localparam int DAG_LOW_W = 16; // In-page part of a pointer
	localparam int DAG_PAGE_W = 7; // Page bits above the in-page part
	localparam int DAG_OFS_W = 7; // Direct-addressing offset field
	localparam int DAG_LEGACY_W = 9; // Legacy page field width
	localparam int DAG_ST1_W = 16; // Status register one width
	localparam int DAG_LEGACY_LSB = 0; // Legacy page field position in status one
	localparam int DAG_NUM_PTR = 8; // Extended auxiliary pointers
	localparam int DAG_SEL_W = 3; // Pointer select width
	localparam int DAG_VEC_W = 2; // Stack-mode code width in the reset vector

	// ****************************************
	// Reset values and fixed steps
	// ****************************************
	localparam logic [DAG_ADDR_W-1:0] DAG_ADDR_RST = 23'h00_0000;
	localparam logic [DAG_LOW_W-1:0] DAG_LOW_RST = 16'h0000;
	localparam logic [DAG_PAGE_W-1:0] DAG_PAGE_RST = 7'h00;
	localparam logic [DAG_ST1_W-1:0] DAG_ST1_RST = 16'h0000;
	localparam logic [DAG_LOW_W-1:0] DAG_STACK_STEP = 16'h0001;
	localparam logic [DAG_PAGE_W-1:0] DAG_LEGACY_ALIGN = 7'h00; // Low bits of a legacy base
	localparam logic [DAG_VEC_W-1:0] DAG_VEC_FAST_RET = 2'h1; // Code for fast-return mode

	// ****************************************
	// Modes and commands
	// ****************************************
	typedef enum logic {
		DAG_STK_ALIGNED32,
		DAG_STK_FAST_RET
	} dag_stack_mode_e;

	typedef enum logic [3:0] {
		DAG_OP_NONE,
		DAG_OP_PTR_LOAD_LOW,
		DAG_OP_PTR_LOAD_FULL,
		DAG_OP_PTR_ADD,
		DAG_OP_IND_ACCESS,
		DAG_OP_IDX_ACCESS,
		DAG_OP_DIR_ACCESS,
		DAG_OP_PAGE_LOAD,
		DAG_OP_LEGACY_LOAD
	} dag_op_e;

	typedef enum logic [2:0] {
		DAG_SOP_NONE,
		DAG_SOP_PUSH,
		DAG_SOP_POP,
		DAG_SOP_SYS_PUSH,
		DAG_SOP_SYS_POP,
		DAG_SOP_LOAD_SP,
		DAG_SOP_LOAD_SSP
	} dag_stk_op_e;
endpackage
`default_nettype wire

//--- verilog/dag_stack.sv
`timescale 1ns/1ps
`default_nettype none
module dag_stack
	import dag_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Control
	input wire dag_stack_mode_e stack_mode_i,
	input wire dag_stk_op_e stk_op_i,
	input wire logic [DAG_ADDR_W-1:0] stk_data_i,
	// Stack addresses
	output logic [DAG_ADDR_W-1:0] sp_addr_o,
	output logic [DAG_ADDR_W-1:0] system_stack_pointer_o
);
	// ****************************************
	// Stack pointer state
	// ****************************************
	logic [DAG_PAGE_W-1:0] page;
	logic [DAG_LOW_W-1:0] sp_low;
	logic [DAG_LOW_W-1:0] ssp_low;
	logic [DAG_PAGE_W-1:0] next_page;
	logic [DAG_LOW_W-1:0] next_sp_low;
	logic [DAG_LOW_W-1:0] next_ssp_low;
	logic aligned;

	// Aligned mode drags the system stack along with every data stack push and pop
	assign aligned = (stack_mode_i == DAG_STK_ALIGNED32);

	// Next values; stacks grow downward and wrap within the shared page
	always_comb begin
		next_page = page;
		next_sp_low = sp_low;
		next_ssp_low = ssp_low;
		case (stk_op_i)
			DAG_SOP_PUSH, DAG_SOP_SYS_PUSH: begin
				if (stk_op_i == DAG_SOP_PUSH || aligned) begin
					next_sp_low = sp_low - DAG_STACK_STEP;
				end
				if (stk_op_i == DAG_SOP_SYS_PUSH || aligned) begin
					next_ssp_low = ssp_low - DAG_STACK_STEP;
				end
			end
			DAG_SOP_POP, DAG_SOP_SYS_POP: begin
				if (stk_op_i == DAG_SOP_POP || aligned) begin
					next_sp_low = sp_low + DAG_STACK_STEP;
				end
				if (stk_op_i == DAG_SOP_SYS_POP || aligned) begin
					next_ssp_low = ssp_low + DAG_STACK_STEP;
				end
			end
			DAG_SOP_LOAD_SP: begin
				next_page = stk_data_i[DAG_ADDR_W-1:DAG_LOW_W];
				next_sp_low = stk_data_i[DAG_LOW_W-1:0];
			end
			DAG_SOP_LOAD_SSP: begin
				next_page = stk_data_i[DAG_ADDR_W-1:DAG_LOW_W];
				next_ssp_low = stk_data_i[DAG_LOW_W-1:0];
			end
			default: begin
				next_page = page;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			page <= DAG_PAGE_RST;
			sp_low <= DAG_LOW_RST;
			ssp_low <= DAG_LOW_RST;
		end else begin
			page <= next_page;
			sp_low <= next_sp_low;
			ssp_low <= next_ssp_low;
		end
	end

	// One page field serves both stacks
	assign sp_addr_o = {page, sp_low};
	assign system_stack_pointer_o = {page, ssp_low};
endmodule
`default_nettype wire

//--- sim/dag_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dag_top_chk
	import dag_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Commands
	input wire logic [DAG_VEC_W-1:0] reset_vec_code_i,
	input wire dag_op_e op_i,
	input wire logic [DAG_ADDR_W-1:0] op_data_i,
	input wire logic [DAG_OFS_W-1:0] dir_offset_i,
	input wire dag_stk_op_e stk_op_i,
	// Results
	input wire logic [DAG_ADDR_W-1:0] addr_o,
	input wire logic addr_valid_o,
	input wire logic [DAG_ADDR_W-1:0] extended_page_pointer_o,
	input wire logic [DAG_ST1_W-1:0] status_register_one_o,
	input wire logic stack_mode_ready_o,
	input wire dag_stack_mode_e stack_mode_o,
	input wire logic [DAG_ADDR_W-1:0] sp_addr_o,
	input wire logic [DAG_ADDR_W-1:0] system_stack_pointer_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// ****************************************
	// Push steps, split by stack mode
	// ****************************************
	sequence s_push_al;
		stack_mode_ready_o && stk_op_i == DAG_SOP_PUSH && stack_mode_o == DAG_STK_ALIGNED32;
	endsequence
	sequence s_push_fr;
		stack_mode_ready_o && stk_op_i == DAG_SOP_PUSH && stack_mode_o == DAG_STK_FAST_RET;
	endsequence
	sequence s_sp_down;
		sp_addr_o[15:0] == $past(sp_addr_o[15:0]) - 16'h0001;
	endsequence
	// ****************************************
	// Checks
	// ****************************************
	chk_access_valid: assert property (op_i inside {DAG_OP_IND_ACCESS, DAG_OP_IDX_ACCESS,
		DAG_OP_DIR_ACCESS} |=> addr_valid_o) else $error("access gave no address");
	chk_valid_cause: assert property (addr_valid_o |-> $past(op_i) inside {DAG_OP_IND_ACCESS,
		DAG_OP_IDX_ACCESS, DAG_OP_DIR_ACCESS}) else $error("address strobe without access");
	chk_dir_addr: assert property (op_i == DAG_OP_DIR_ACCESS |=> addr_o ==
		$past(extended_page_pointer_o) + 23'($past(dir_offset_i))) else $error("direct address");
	chk_page_load: assert property (op_i == DAG_OP_PAGE_LOAD |=>
		extended_page_pointer_o == $past(op_data_i)) else $error("page pointer load");
	chk_legacy_load: assert property (op_i == DAG_OP_LEGACY_LOAD |=>
		status_register_one_o == {7'h00, $past(op_data_i[8:0])} &&
		extended_page_pointer_o == {7'h00, $past(op_data_i[8:0]), 7'h00})
		else $error("legacy page load");
	chk_page_share: assert property (sp_addr_o[22:16] == system_stack_pointer_o[22:16])
		else $error("stack pages differ");
	chk_push_aligned: assert property (s_push_al |=> s_sp_down ##0
		system_stack_pointer_o[15:0] == $past(system_stack_pointer_o[15:0]) - 16'h0001)
		else $error("aligned push");
	chk_push_fast: assert property (s_push_fr |=> s_sp_down ##0
		$stable(system_stack_pointer_o)) else $error("fast push moved system stack");
	chk_mode_code: assert property ($rose(stack_mode_ready_o) |-> stack_mode_o ==
		(reset_vec_code_i == DAG_VEC_FAST_RET ? DAG_STK_FAST_RET : DAG_STK_ALIGNED32))
		else $error("stack mode from code");
	chk_mode_hold: assert property (stack_mode_ready_o |=>
		stack_mode_ready_o && $stable(stack_mode_o)) else $error("stack mode changed");
endmodule
bind dag_top dag_top_chk chk (.clock_i, .rst_b_i, .reset_vec_code_i, .op_i, .op_data_i,
	.dir_offset_i, .stk_op_i, .addr_o, .addr_valid_o, .extended_page_pointer_o,
	.status_register_one_o, .stack_mode_ready_o, .stack_mode_o, .sp_addr_o,
	.system_stack_pointer_o);
`default_nettype wire

//--- sim/dag_dmem.sv
`timescale 1ns/1ps
`default_nettype none
module dag_dmem
	import dag_pkg::*;
(
	// Address side
	input wire logic clock_i,
	input wire logic [DAG_ADDR_W-1:0] addr_i,
	input wire logic valid_i,
	// Record
	output logic [DAG_ADDR_W-1:0] last_o
);
	// Data memory only records the word address it was handed
	always_ff @(posedge clock_i) begin
		if (valid_i) begin
			last_o <= addr_i;
		end
	end
endmodule
`default_nettype wire

//--- sim/tb_dsp_data_address_generation.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_data_address_generation
	import dag_pkg::*;
;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [1:0] reset_vec_code_i = 2'h0;
	dag_op_e op_i = DAG_OP_NONE;
	dag_stk_op_e stk_op_i = DAG_SOP_NONE;
	logic [2:0] ptr_sel_i = 3'h0;
	logic [2:0] rd_sel_i = 3'h0;
	logic [22:0] op_data_i = 23'h00_0000;
	logic [22:0] stk_data_i = 23'h00_0000;
	logic [6:0] dir_offset_i = 7'h00;
	logic [22:0] addr_o, rd_ptr_o, extended_page_pointer_o, sp_addr_o, system_stack_pointer_o;
	logic [22:0] seen;
	logic [15:0] status_register_one_o;
	logic addr_valid_o, stack_mode_ready_o;
	dag_stack_mode_e stack_mode_o;
	int failures = 0;
	int total_checks = 0;
	// ****************************************
	// Design, memory and clock
	// ****************************************
	dag_top DUT (.clock_i, .rst_b_i, .reset_vec_code_i, .op_i, .ptr_sel_i, .op_data_i,
		.dir_offset_i, .stk_op_i, .stk_data_i, .rd_sel_i, .addr_o, .addr_valid_o, .rd_ptr_o,
		.extended_page_pointer_o, .status_register_one_o, .stack_mode_ready_o,
		.stack_mode_o, .sp_addr_o, .system_stack_pointer_o);
	dag_dmem mem (.clock_i, .addr_i(addr_o), .valid_i(addr_valid_o), .last_o(seen));
	initial begin
		forever #10 clock_i = ~clock_i;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Mode code must stay put until the mode is captured
	task automatic do_reset(input logic [1:0] code);
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		reset_vec_code_i <= code;
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 10 && stack_mode_ready_o !== 1'b1; i++) @(posedge clock_i);
		#1;
		if (stack_mode_ready_o !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic cmd(input dag_op_e o, input logic [2:0] s, input logic [22:0] d,
		input logic [6:0] f);
		@(posedge clock_i);
		op_i <= o;
		ptr_sel_i <= s;
		op_data_i <= d;
		dir_offset_i <= f;
		@(posedge clock_i);
		op_i <= DAG_OP_NONE;
		#1;
	endtask
	// Memory records one edge after the strobe
	task automatic acc(input dag_op_e o, input logic [2:0] s, input logic [22:0] d,
		input logic [6:0] f, input logic [22:0] e, input string n);
		cmd(o, s, d, f);
		@(posedge clock_i);
		#1;
		chk(n, e, seen);
	endtask
	task automatic rdp(input logic [2:0] s, input logic [22:0] e, input string n);
		@(posedge clock_i);
		rd_sel_i <= s;
		repeat (2) @(posedge clock_i);
		#1;
		chk(n, e, rd_ptr_o);
	endtask
	task automatic stk(input dag_stk_op_e o, input logic [22:0] d);
		@(posedge clock_i);
		stk_op_i <= o;
		stk_data_i <= d;
		@(posedge clock_i);
		stk_op_i <= DAG_SOP_NONE;
		#1;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_ptr();
		cmd(DAG_OP_PTR_LOAD_FULL, 3'h2, 23'h45_FFFE, 7'h00);
		rdp(3'h2, 23'h45_FFFE, "full load");
		acc(DAG_OP_IND_ACCESS, 3'h2, 23'h00_0003, 7'h00, 23'h45_FFFE, "ind addr");
		rdp(3'h2, 23'h45_0001, "page wrap");
		cmd(DAG_OP_PTR_LOAD_LOW, 3'h2, 23'h7F_1234, 7'h00);
		rdp(3'h2, 23'h45_1234, "low load");
		cmd(DAG_OP_PTR_ADD, 3'h2, 23'h00_F000, 7'h00);
		rdp(3'h2, 23'h45_0234, "ptr add");
		acc(DAG_OP_IDX_ACCESS, 3'h2, 23'h00_FE00, 7'h00, 23'h45_0034, "idx addr");
		rdp(3'h3, 23'h00_0000, "other ptr");
	endtask
	task automatic t_dir();
		cmd(DAG_OP_PAGE_LOAD, 3'h0, 23'h12_FFF0, 7'h00);
		chk("page", 23'h12_FFF0, extended_page_pointer_o);
		acc(DAG_OP_DIR_ACCESS, 3'h0, 23'h00_0000, 7'h7F, 23'h13_006F, "dir addr");
		cmd(DAG_OP_LEGACY_LOAD, 3'h0, 23'h00_01A5, 7'h00);
		chk("status", 23'h00_01A5, {7'h00, status_register_one_o});
		chk("legacy page", 23'h00_D280, extended_page_pointer_o);
		acc(DAG_OP_DIR_ACCESS, 3'h0, 23'h00_0000, 7'h05, 23'h00_D285, "legacy dir");
	endtask
	task automatic t_stack(input logic [1:0] code);
		logic fast;
		fast = (code == DAG_VEC_FAST_RET);
		do_reset(code);
		chk("mode", 23'(fast), 23'(stack_mode_o));
		stk(DAG_SOP_LOAD_SP, 23'h05_0000);
		chk("ssp page", 23'h05_0000, system_stack_pointer_o);
		stk(DAG_SOP_PUSH, 23'h00_0000);
		chk("sp push", 23'h05_FFFF, sp_addr_o);
		chk("ssp push", fast ? 23'h05_0000 : 23'h05_FFFF, system_stack_pointer_o);
		stk(DAG_SOP_SYS_PUSH, 23'h00_0000);
		chk("sp sys push", fast ? 23'h05_FFFF : 23'h05_FFFE, sp_addr_o);
		chk("ssp sys push", fast ? 23'h05_FFFF : 23'h05_FFFE, system_stack_pointer_o);
		stk(DAG_SOP_POP, 23'h00_0000);
		chk("sp pop", fast ? 23'h05_0000 : 23'h05_FFFF, sp_addr_o);
		chk("ssp pop", 23'h05_FFFF, system_stack_pointer_o);
		stk(DAG_SOP_SYS_POP, 23'h00_0000);
		chk("sp sys pop", 23'h05_0000, sp_addr_o);
		chk("ssp sys pop", 23'h05_0000, system_stack_pointer_o);
		stk(DAG_SOP_LOAD_SSP, 23'h09_1234);
		chk("sp page", 23'h09_0000, sp_addr_o);
		chk("ssp load", 23'h09_1234, system_stack_pointer_o);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset(2'h0);
		chk("reset ptr", 23'h00_0000, rd_ptr_o);
		t_ptr();
		t_dir();
		for (int c = 0; c < 4; c++) t_stack(2'(c));
		print_verdict();
	end
endmodule
`default_nettype wire
